// ### rtl/rtc_defs.svh
// register offsets, field positions, reset values and counts for the rtc block
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH

`define RTC_ADDR_W          12
`define RTC_OFF_CSR         12'h000
`define RTC_OFF_FLAGS       12'h004
`define RTC_OFF_CR2         12'h008
`define RTC_OFF_CR1         12'h00C
`define RTC_OFF_SECONDS     12'h010
`define RTC_OFF_MINUTES     12'h014
`define RTC_OFF_HOURS       12'h018
`define RTC_OFF_WEEKDAY     12'h01C

`define RTC_CSR_RESET       8'h08
`define RTC_CSR_WMASK       8'h7F
`define RTC_CR1_RESET       8'h00
`define RTC_CR2_RESET       8'h00
`define RTC_CR1_RUN_BIT     7
`define RTC_CR1_RST_BIT     6
`define RTC_SRC_SUB_DIV4    4'h8
`define RTC_SRC_TAP_MAX     4'h7

`define RTC_FLG_OVF         7
`define RTC_FLG_WEEK        6
`define RTC_FLG_DAY         5
`define RTC_FLG_HOUR        4
`define RTC_FLG_MIN         3
`define RTC_FLG_SEC         2
`define RTC_FLG_HALF        1
`define RTC_FLG_QUARTER     0

`define RTC_SUB_HZ          32768
`define RTC_SUB_PRESCALE    4
`define RTC_QUARTERS_PER_S  4
`define RTC_QUARTER_TICKS   ((`RTC_SUB_HZ / `RTC_SUB_PRESCALE) / `RTC_QUARTERS_PER_S)
`define RTC_SECS_PER_MIN    60
`define RTC_MINS_PER_HOUR   60
`define RTC_HOURS_PER_DAY   24
`define RTC_DAYS_PER_WEEK   7
`define RTC_SYS_DIV_W       16

`endif

// ### rtl/rtc_pkg.sv
// types shared by the rtc block
`default_nettype none
package rtc_pkg;
   typedef enum logic [2:0] {
      MODE_ACTIVE,
      MODE_SLEEP,
      MODE_SUBACTIVE,
      MODE_SUBSLEEP,
      MODE_WATCH,
      MODE_STANDBY
   } power_mode_t;

   typedef struct packed {
      logic [2:0] out_sel;
      logic [3:0] src_sel;
   } clock_select_t;

   typedef struct packed {
      logic [7:0] seconds;
      logic [7:0] minutes;
      logic [7:0] hours;
      logic [7:0] weekday;
   } calendar_t;
endpackage
`default_nettype wire

// ### rtl/rtc_mod_counter.sv
// wrapping modulo counter with increment and synchronous clear
`default_nettype none
module rtc_mod_counter #(
   parameter int W   = 8,
   parameter int MOD = 60
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // control
   input  wire logic         clr,
   input  wire logic         inc,
   // state
   output logic [W-1:0]      value,
   output logic              wrap
);
   localparam logic [W-1:0] LAST = W'(MOD - 1);
   logic [W-1:0] next_value;

   assign wrap = inc && (value == LAST);

   always_comb
   begin
      next_value = value;
      if (clr)
         next_value = '0;
      else if (wrap)
         next_value = '0;
      else if (inc)
         next_value = value + W'(1);
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         value <= '0;
      else
         value <= next_value;
   end
endmodule
`default_nettype wire

// ### rtl/rtc_clock_select_irq.sv
// rtc clock source and output selection, calendar, free counter and flags
//
// Functional notes
// - non-subclock source: free 8-bit counter, calendar stops
// - free counter counts only while run set
// - seconds read returns free counter value on non-subclock source
// - overflow raises request when enable bit set
// - system clock divisions output only active/sleep
// - undivided subclock output in five modes
// - select register bit 7 reads zero
// - bits 6-4 choose clock output pin source
// - source code 1000 is subclock/4, reset value
// - flags sticky until software clears them
// - write 0 clears flag, 1 leaves it
// - flag positions overflow down to quarter-second
// - software reset bit clears all flags
// - week event when weekday returns to zero
// - half and quarter second periodic events
`include "rtc_defs.svh"
`default_nettype none
module rtc_clock_select_irq
   import rtc_pkg::*;
(
   // clock and reset
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   // apb slave
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [`RTC_ADDR_W-1:0] paddr,
   input  wire logic [31:0]            pwdata,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   // subclock and chip state
   input  wire logic                   subclk,
   input  wire power_mode_t            power_mode,
   input  wire logic                   port_clkout_en,
   // clock output pin
   output logic                        clock_output_pin,
   output logic                        clock_output_pin_oe,
   // interrupt
   output logic                        irq
);
   // register state
   clock_select_t csr;
   clock_select_t next_csr;
   logic [7:0]    flags;
   logic [7:0]    next_flags;
   logic [7:0]    cr1;
   logic [7:0]    next_cr1;
   logic [7:0]    cr2;
   logic [7:0]    next_cr2;
   logic [31:0]   next_prdata;

   // timing state
   logic                      sub_q;
   logic                      next_sub_q;
   logic [`RTC_SYS_DIV_W-1:0] sys_div;
   logic [`RTC_SYS_DIV_W-1:0] next_sys_div;
   logic [7:0]                free_cnt;
   logic [7:0]                next_free_cnt;
   logic                      next_clkout;

   calendar_t  cal;
   logic [1:0] pre_cnt;
   logic [1:0] quarter_idx;
   logic [$clog2(`RTC_QUARTER_TICKS)-1:0] quarter_cnt;
   logic       pre_wrap;
   logic       quarter_wrap;
   logic       sec_tick;
   logic       sec_wrap;
   logic       min_wrap;
   logic       hour_wrap;
   logic       day_wrap;

   logic       wr_en;
   logic       rd_setup;
   logic       addr_ok;
   logic       run;
   logic       sw_rst;
   logic       cal_mode;
   logic       sub_tick;
   logic       tap_tick;
   logic       cal_inc;
   logic       ovf;
   logic [7:0] events;
   logic [7:0] wbyte;

   assign wbyte    = pwdata[7:0];
   assign run      = cr1[`RTC_CR1_RUN_BIT];
   assign sw_rst   = cr1[`RTC_CR1_RST_BIT];
   assign cal_mode = (csr.src_sel == `RTC_SRC_SUB_DIV4);
   assign sub_tick = subclk && !sub_q;
   assign cal_inc  = run && cal_mode && pre_wrap;

   // apb decode
   always_comb
   begin
      case (paddr)
         `RTC_OFF_CSR, `RTC_OFF_FLAGS, `RTC_OFF_CR2, `RTC_OFF_CR1,
         `RTC_OFF_SECONDS, `RTC_OFF_MINUTES, `RTC_OFF_HOURS, `RTC_OFF_WEEKDAY:
            addr_ok = 1'b1;
         default:
            addr_ok = 1'b0;
      endcase
   end

   assign pready   = 1'b1;
   assign pslverr  = psel && penable && !addr_ok;
   assign wr_en    = psel && penable && pwrite && addr_ok;
   assign rd_setup = psel && !penable && !pwrite;

   // system clock taps for the free counter
   always_comb
   begin
      tap_tick = 1'b0;
      if (csr.src_sel <= `RTC_SRC_TAP_MAX)
         tap_tick = &(sys_div[7:0] | (8'hFE << csr.src_sel[2:0]));
   end

   // subclock divider and calendar chain
   rtc_mod_counter #(.W(2), .MOD(`RTC_SUB_PRESCALE)) u_pre (
      .clk   (pclk),
      .rst_n (presetn),
      .clr   (sw_rst),
      .inc   (sub_tick && cal_mode && run),
      .value (pre_cnt),
      .wrap  (pre_wrap)
   );

   rtc_mod_counter #(.W($clog2(`RTC_QUARTER_TICKS)), .MOD(`RTC_QUARTER_TICKS)) u_quarter (
      .clk   (pclk),
      .rst_n (presetn),
      .clr   (sw_rst),
      .inc   (cal_inc),
      .value (quarter_cnt),
      .wrap  (quarter_wrap)
   );

   rtc_mod_counter #(.W(2), .MOD(`RTC_QUARTERS_PER_S)) u_qidx (
      .clk   (pclk),
      .rst_n (presetn),
      .clr   (sw_rst),
      .inc   (quarter_wrap),
      .value (quarter_idx),
      .wrap  (sec_tick)
   );

   rtc_mod_counter #(.W(8), .MOD(`RTC_SECS_PER_MIN)) u_sec (
      .clk   (pclk),
      .rst_n (presetn),
      .clr   (sw_rst),
      .inc   (sec_tick),
      .value (cal.seconds),
      .wrap  (sec_wrap)
   );

   rtc_mod_counter #(.W(8), .MOD(`RTC_MINS_PER_HOUR)) u_min (
      .clk   (pclk),
      .rst_n (presetn),
      .clr   (sw_rst),
      .inc   (sec_wrap),
      .value (cal.minutes),
      .wrap  (min_wrap)
   );

   rtc_mod_counter #(.W(8), .MOD(`RTC_HOURS_PER_DAY)) u_hour (
      .clk   (pclk),
      .rst_n (presetn),
      .clr   (sw_rst),
      .inc   (min_wrap),
      .value (cal.hours),
      .wrap  (hour_wrap)
   );

   rtc_mod_counter #(.W(8), .MOD(`RTC_DAYS_PER_WEEK)) u_day (
      .clk   (pclk),
      .rst_n (presetn),
      .clr   (sw_rst),
      .inc   (hour_wrap),
      .value (cal.weekday),
      .wrap  (day_wrap)
   );

   // free counter
   always_comb
   begin
      next_free_cnt = free_cnt;
      ovf           = 1'b0;
      if (sw_rst)
         next_free_cnt = 8'h00;
      else if (!cal_mode && run && tap_tick)
      begin
         next_free_cnt = free_cnt + 8'h01;
         ovf           = (free_cnt == 8'hFF);
      end
   end

   // event vector
   always_comb
   begin
      events                     = 8'h00;
      events[`RTC_FLG_OVF]       = ovf;
      events[`RTC_FLG_WEEK]      = day_wrap;
      events[`RTC_FLG_DAY]       = hour_wrap;
      events[`RTC_FLG_HOUR]      = min_wrap;
      events[`RTC_FLG_MIN]       = sec_wrap;
      events[`RTC_FLG_SEC]       = sec_tick;
      events[`RTC_FLG_HALF]      = quarter_wrap && quarter_idx[0];
      events[`RTC_FLG_QUARTER]   = quarter_wrap;
   end

   // register next values
   always_comb
   begin
      next_csr   = csr;
      next_cr1   = cr1;
      next_cr2   = cr2;
      next_flags = flags;
      if (wr_en)
      begin
         case (paddr)
            `RTC_OFF_CSR:
               next_csr = clock_select_t'(7'(wbyte & `RTC_CSR_WMASK));
            `RTC_OFF_CR1:
               next_cr1 = wbyte;
            `RTC_OFF_CR2:
               next_cr2 = wbyte;
            `RTC_OFF_FLAGS:
               next_flags = flags & wbyte;
            default:
               next_cr1 = cr1;
         endcase
      end
      if (sw_rst)
         next_flags = 8'h00;
      else
         next_flags = next_flags | events;
   end

   // read data
   always_comb
   begin
      next_prdata = prdata;
      if (rd_setup)
      begin
         case (paddr)
            `RTC_OFF_CSR:
               next_prdata = {24'h000000, 1'b0, csr};
            `RTC_OFF_FLAGS:
               next_prdata = {24'h000000, flags};
            `RTC_OFF_CR1:
               next_prdata = {24'h000000, cr1};
            `RTC_OFF_CR2:
               next_prdata = {24'h000000, cr2};
            `RTC_OFF_SECONDS:
               next_prdata = {24'h000000, cal_mode ? cal.seconds : free_cnt};
            `RTC_OFF_MINUTES:
               next_prdata = {24'h000000, cal.minutes};
            `RTC_OFF_HOURS:
               next_prdata = {24'h000000, cal.hours};
            `RTC_OFF_WEEKDAY:
               next_prdata = {24'h000000, cal.weekday};
            default:
               next_prdata = 32'h00000000;
         endcase
      end
   end

   // clock output select
   always_comb
   begin
      next_sys_div = sys_div + `RTC_SYS_DIV_W'(1);
      next_sub_q   = subclk;
      next_clkout  = 1'b0;
      if (csr.out_sel[0])
      begin
         if (power_mode != MODE_STANDBY)
            next_clkout = subclk;
      end
      else if (power_mode == MODE_ACTIVE || power_mode == MODE_SLEEP)
      begin
         case (csr.out_sel[2:1])
            2'b00:
               next_clkout = sys_div[1];
            2'b01:
               next_clkout = sys_div[2];
            2'b10:
               next_clkout = sys_div[3];
            2'b11:
               next_clkout = sys_div[4];
            default:
               next_clkout = 1'b0;
         endcase
      end
   end

   assign clock_output_pin_oe = port_clkout_en;
   assign irq = |(flags & cr2);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         csr              <= clock_select_t'(7'(`RTC_CSR_RESET));
         cr1              <= `RTC_CR1_RESET;
         cr2              <= `RTC_CR2_RESET;
         flags            <= 8'h00;
         prdata           <= 32'h00000000;
         sys_div          <= '0;
         sub_q            <= 1'b0;
         free_cnt         <= 8'h00;
         clock_output_pin <= 1'b0;
      end
      else
      begin
         csr              <= next_csr;
         cr1              <= next_cr1;
         cr2              <= next_cr2;
         flags            <= next_flags;
         prdata           <= next_prdata;
         sys_div          <= next_sys_div;
         sub_q            <= next_sub_q;
         free_cnt         <= next_free_cnt;
         clock_output_pin <= next_clkout;
      end
   end
endmodule
`default_nettype wire

// ### testbench/rtc_chk.sv
// assertion checker for the rtc block
`default_nettype none
module rtc_chk
   import rtc_pkg::*;
(
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // chip state and outputs
   input wire logic        subclk,
   input wire power_mode_t power_mode,
   input wire logic        port_clkout_en,
   input wire logic        clock_output_pin,
   input wire logic        clock_output_pin_oe,
   input wire logic        irq
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic acc;
   assign acc = psel && penable;
   AST_OE: assert property (clock_output_pin_oe == port_clkout_en)
      else $error("pin enable differs from port enable");
   AST_RSV7: assert property (acc && !pwrite && paddr == 12'h000 |-> !prdata[7])
      else $error("select bit 7 reads one");
   AST_HIZ: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
      else $error("upper read data not zero");
   AST_ERR: assert property (acc && (paddr[11:5] != 7'h00 || paddr[1:0] != 2'h0) |-> pslverr)
      else $error("unmapped access not refused");
   AST_NOERR: assert property (acc && paddr[11:5] == 7'h00 && paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("mapped access refused");
   AST_STBY: assert property (
      (power_mode == MODE_STANDBY)[*2] |-> !clock_output_pin)
      else $error("clock out active in standby");
   AST_SUBACT: assert property (
      (power_mode == MODE_SUBACTIVE)[*2] ##0 clock_output_pin |-> $past(subclk))
      else $error("system division out in subactive");
   AST_IRQ_CLR: assert property (
      acc && pwrite && paddr == 12'h008 && pwdata[7:0] == 8'h00 |=> !irq)
      else $error("request with all enables clear");
   cover property (irq);
   cover property (power_mode == MODE_SUBACTIVE && clock_output_pin);
   cover property (acc && pslverr);
   cover property (power_mode == MODE_WATCH && clock_output_pin);
endmodule
bind rtc_clock_select_irq rtc_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .subclk, .power_mode, .port_clkout_en,
   .clock_output_pin, .clock_output_pin_oe, .irq);
`default_nettype wire

// ### testbench/test_rtc_clock_select_irq.sv
// self-checking bench for the rtc block
`include "rtc_defs.svh"
`default_nettype none
module test_rtc_clock_select_irq
   import rtc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic        subclk, sub_run, port_clkout_en, clock_output_pin, clock_output_pin_oe, irq;
   power_mode_t power_mode;
   int          n_fail, check_count;
   rtc_clock_select_irq uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .subclk, .power_mode, .port_clkout_en, .clock_output_pin,
      .clock_output_pin_oe, .irq);
   always #2.5 pclk = ~pclk;
   always @(posedge pclk)
      if (sub_run)
         subclk <= ~subclk;
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
                       output logic [31:0] q, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] q;
      logic        e;
      xfer(1'b1, a, d, q, e);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] x, input string n);
      logic [31:0] q;
      logic        e;
      xfer(1'b0, a, 8'h00, q, e);
      chk(n, x, q);
   endtask
   task automatic per(output int p);
      int   c, r, k;
      logic l;
      repeat (40) @(posedge pclk);
      l = clock_output_pin;
      c = 0;
      r = 0;
      for (k = 0; k < 200 && r < 2; k++)
      begin
         @(posedge pclk);
         c++;
         if (clock_output_pin === 1'b1 && l === 1'b0)
         begin
            r++;
            if (r == 1)
               c = 0;
         end
         l = clock_output_pin;
      end
      p = (r == 2) ? c : 0;
   endtask
   task automatic t_regs;
      logic [31:0] q;
      logic        e;
      rd(`RTC_OFF_CSR, 32'h08, "select reset");
      wr(`RTC_OFF_CSR, 8'hF8);
      rd(`RTC_OFF_CSR, 32'h78, "select bit7");
      xfer(1'b0, 12'h040, 8'h00, q, e);
      chk("unmapped error", 32'h1, {31'h0, e});
      chk("unmapped data", 32'h0, q);
   endtask
   task automatic t_free;
      logic [31:0] q0, q1;
      logic        e;
      logic [7:0]  step;
      wr(`RTC_OFF_CR2, 8'h80);
      wr(`RTC_OFF_CSR, 8'h00);
      wr(`RTC_OFF_CR1, 8'h80);
      xfer(1'b0, `RTC_OFF_SECONDS, 8'h00, q0, e);
      repeat (600) @(posedge pclk);
      xfer(1'b0, `RTC_OFF_SECONDS, 8'h00, q1, e);
      step = q1[7:0] - q0[7:0];
      chk("free count step", 32'h1, {31'h0, (step inside {8'h2D, 8'h2E})});
      wr(`RTC_OFF_CR1, 8'h00);
      xfer(1'b0, `RTC_OFF_SECONDS, 8'h00, q0, e);
      repeat (20) @(posedge pclk);
      rd(`RTC_OFF_SECONDS, q0, "free holds");
      rd(`RTC_OFF_FLAGS, 32'h80, "overflow flag");
      chk("overflow irq", 32'h1, {31'h0, irq});
      wr(`RTC_OFF_FLAGS, 8'hFF);
      rd(`RTC_OFF_FLAGS, 32'h80, "write one keeps");
      wr(`RTC_OFF_FLAGS, 8'h7F);
      rd(`RTC_OFF_FLAGS, 32'h00, "write zero clears");
      chk("irq cleared", 32'h0, {31'h0, irq});
   endtask
   task automatic t_cal;
      wr(`RTC_OFF_CR2, 8'h01);
      wr(`RTC_OFF_CSR, 8'h08);
      sub_run <= 1'b1;
      wr(`RTC_OFF_CR1, 8'h80);
      repeat (34000) @(posedge pclk);
      rd(`RTC_OFF_FLAGS, 32'h03, "half quarter flags");
      chk("quarter irq", 32'h1, {31'h0, irq});
      wr(`RTC_OFF_CR2, 8'h00);
      @(posedge pclk);
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(`RTC_OFF_FLAGS, 8'hFE);
      rd(`RTC_OFF_FLAGS, 32'h02, "quarter cleared");
      wr(`RTC_OFF_CR1, 8'hC0);
      rd(`RTC_OFF_FLAGS, 32'h00, "software reset");
      wr(`RTC_OFF_CR1, 8'h00);
   endtask
   task automatic t_clk;
      int p;
      port_clkout_en <= 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         wr(`RTC_OFF_CSR, {1'b0, 3'(2 * i), 4'h8});
         per(p);
         chk("system division", 32'(4 << i), 32'(p));
      end
      chk("clock pin enable", 32'h1, {31'h0, clock_output_pin_oe});
      power_mode <= MODE_SLEEP;
      per(p);
      chk("division in sleep", 32'h20, 32'(p));
      power_mode <= MODE_SUBACTIVE;
      per(p);
      chk("no division in subactive", 32'h0, 32'(p));
      wr(`RTC_OFF_CSR, 8'h18);
      per(p);
      chk("subclock in subactive", 32'h2, 32'(p));
      power_mode <= MODE_SUBSLEEP;
      per(p);
      chk("subclock in subsleep", 32'h2, 32'(p));
      power_mode <= MODE_WATCH;
      per(p);
      chk("subclock in watch", 32'h2, 32'(p));
      power_mode <= MODE_STANDBY;
      per(p);
      chk("no subclock in standby", 32'h0, 32'(p));
   endtask
   task automatic tally_and_finish;
      if (n_fail == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial
   begin
      #400us;
      n_fail++;
      tally_and_finish;
   end
   initial
   begin
      pclk = 0;
      presetn = 0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {subclk, sub_run, port_clkout_en} = '0;
      power_mode = MODE_ACTIVE;
      n_fail = 0;
      check_count = 0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_free;
      t_cal;
      t_clk;
      tally_and_finish;
   end
endmodule
`default_nettype wire
